// [inc/fbm_pkg.sv]
// package for the flash control and boot mapping block
package fbm_pkg;
    localparam logic [7:0] FMC_ADDR = 8'hfb;
    localparam int BIT_BSH = 7;
    localparam int BIT_BSL = 6;
    localparam int BIT_PVF = 5;
    localparam int BIT_RSV = 4;
    localparam logic [3:0] FC_RESET = 4'h0;
    localparam logic [3:0] FC_BYTE = 4'h5;
    localparam logic [3:0] FC_PAGE = 4'hc;
    localparam logic [3:0] FC_BLOCK = 4'h3;
    localparam logic [3:0] FC_FULL = 4'ha;
    localparam logic [15:0] BOOT_BASE = 16'hfc00;
    localparam logic [14:0] PROT_ADDR = 15'h7fff;
    localparam logic [7:0] PROT_ON = 8'h50;
    localparam logic [7:0] ERASED = 8'hff;
    localparam int CLK_MHZ = 100;
    localparam int WRITE_US = 2500;
    localparam int ERASE_US = 5000;
    localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
    localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
    localparam int PAGE_LSB = 5;
    localparam int BLOCK_LSB = 8;

    typedef enum logic [1:0] {
        OP_BYTE = 2'b00,
        OP_PAGE = 2'b01,
        OP_BLOCK = 2'b10,
        OP_FULL = 2'b11
    } fbm_op_e;

    typedef struct packed {
        logic we;
        logic [14:0] addr;
        logic [7:0] wdata;
    } fbm_arr_s;

    typedef struct packed {
        logic sfr_we;
        logic [7:0] sfr_addr;
        logic [7:0] sfr_wdata;
    } fbm_sfr_s;
endpackage

// [rtl/fbm_timer.sv]
// operation duration timer, not reachable by software
module fbm_timer #(
    parameter int WIDTH = 20
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic i_start,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_busy,
    output logic o_done
);
    logic [WIDTH-1:0] cnt;

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            cnt <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_start && !o_busy)
            begin
                cnt <= i_count;
                o_busy <= 1'b1;
            end
            else if (o_busy)
            begin
                if (cnt <= 1)
                begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule

// [rtl/fbm_top.sv]
// flash sequencer with boot rom mapping and mode control register
//Contract
// - full erase 32K, block erase 256 bytes, page erase 32 bytes
// - byte program completes within 2.5 ms onto erased byte
// - every erase finishes within 5 ms regardless of size
// - erased bytes read back all ones
// - protection byte sits at the top flash address
// - both select bits zero maps user memory over all 64K
// - normal reset fetches from zero, internal or external per access pin
// - strobe and access pin low, latch high at reset boots rom
// - boot rom is 1K at 63K to 64K
// - select 01 maps user below 63K and boot rom above
// - return crossing below 63K clears both select bits when they are 01 or 10
// - select 10 maps rom high, high bit cleared in user range
// - select 11 maps boot rom across whole space
// - erase and program only from boot rom upper region
// - address from data pointer pair, data from accumulator
// - flash reads and fetches blocked while cycle runs
// - bit 5 reads one while programming voltage present
// - function code resets 0000 with four defined codes
// - 50h enables protection, taken only at reset release
// - protected: only full erase code writable outside internal flash; code also blocks the others from internal flash while select is 01
// - operation duration set by internal timer only
module fbm_top
    import fbm_pkg::*;
#(
    parameter int SIZE = 32768,
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_STRAP_PROGRAM_STORE_STROBE_N,
    input wire logic I_STRAP_ADDRESS_LATCH_N,
    input wire logic I_STRAP_EXTERNAL_ACCESS_SELECT_N,
    input wire fbm_pkg::fbm_sfr_s I_SFR,
    output logic [7:0] O_SFR_RDATA,
    input wire logic [15:0] I_FETCH_ADDR,
    input wire logic I_FETCH_VALID,
    input wire logic I_RETURN,
    input wire logic [15:0] I_DATA_POINTER_PAIR,
    input wire logic [7:0] I_ACC,
    input wire logic I_OP_START,
    input wire logic I_READ_VALID,
    input wire logic [14:0] I_READ_ADDR,
    output logic [7:0] O_READ_DATA,
    output logic O_SEL_BOOT_ROM,
    output logic O_SEL_EXTERNAL,
    output logic O_FLASH_STALL,
    output logic [15:0] O_START_ADDR,
    output logic O_PROTECTED,
    output logic O_OP_DONE
);
    import fbm_pkg::*;

    logic [7:0] mem [0:SIZE-1];
    logic boot_select_high;
    logic boot_select_low;
    logic [3:0] func_code;
    logic protect;
    logic ext_mode;
    logic boot_mode;
    logic rst_seen;
    logic hv_busy;
    logic hv_done;
    logic start_op;
    logic [19:0] op_cycles;
    fbm_op_e op;
    logic [14:0] op_addr;
    logic [7:0] op_data;
    logic [14:0] erase_mask;
    logic in_top;
    logic from_internal;
    logic fc_write_ok;
    logic [3:0] next_func;

    function automatic logic above_63k(input logic [15:0] a);
        above_63k = (a >= BOOT_BASE);
    endfunction

    // straps only land after the reset is released
    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            rst_seen <= 1'b0;
            ext_mode <= 1'b0;
            boot_mode <= 1'b0;
        end
        else if (!rst_seen)
        begin
            rst_seen <= 1'b1;
            ext_mode <= I_STRAP_EXTERNAL_ACCESS_SELECT_N == 1'b0;
            boot_mode <= !I_STRAP_PROGRAM_STORE_STROBE_N
                && !I_STRAP_EXTERNAL_ACCESS_SELECT_N
                && I_STRAP_ADDRESS_LATCH_N;
        end
    end

    // protection byte caught once; full erase clears it at once, other new values wait for next reset
    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            protect <= 1'b0;
        else if (!rst_seen)
        begin
            // unwritten cell counts as unprotected, never unknown
            case (mem[PROT_ADDR])
                PROT_ON: protect <= 1'b1;
                default: protect <= 1'b0;
            endcase
        end
        else if (hv_done && op == OP_FULL)
            protect <= 1'b0;
    end

    assign in_top = above_63k(I_FETCH_ADDR);
    assign from_internal = !ext_mode && !boot_select_low && !in_top;

    always_comb
    begin
        next_func = I_SFR.sfr_wdata[3:0];
        fc_write_ok = !protect || from_internal
            || next_func == FC_FULL;
    end

    // select bits: software sets, hardware clears on return below 63K
    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            boot_select_high <= 1'b0;
            boot_select_low <= 1'b0;
        end
        else if (!rst_seen)
        begin
            boot_select_high <= boot_mode_strap();
            boot_select_low <= boot_mode_strap();
        end
        else if (I_RETURN && I_FETCH_VALID && !in_top
            && (boot_select_high ^ boot_select_low))
        begin
            boot_select_high <= 1'b0;
            boot_select_low <= 1'b0;
        end
        else if (I_SFR.sfr_we && I_SFR.sfr_addr == FMC_ADDR)
        begin
            boot_select_high <= I_SFR.sfr_wdata[BIT_BSH];
            boot_select_low <= I_SFR.sfr_wdata[BIT_BSL];
        end
        else if (boot_select_high && !boot_select_low && I_FETCH_VALID
            && !in_top)
            boot_select_high <= 1'b0;
    end

    function automatic logic boot_mode_strap();
        boot_mode_strap = !I_STRAP_PROGRAM_STORE_STROBE_N
            && !I_STRAP_EXTERNAL_ACCESS_SELECT_N
            && I_STRAP_ADDRESS_LATCH_N;
    endfunction

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            func_code <= FC_RESET;
        else if (I_SFR.sfr_we && I_SFR.sfr_addr == FMC_ADDR && fc_write_ok)
            func_code <= next_func;
    end

    // voltage flag mirrors the timer, not writable
    assign O_SFR_RDATA = {boot_select_high, boot_select_low,
        hv_busy, 1'b0, func_code};

    // map decode
    always_comb
    begin
        case ({boot_select_high, boot_select_low})
            2'b00: O_SEL_BOOT_ROM = 1'b0;
            2'b01: O_SEL_BOOT_ROM = in_top;
            2'b10: O_SEL_BOOT_ROM = in_top;
            2'b11: O_SEL_BOOT_ROM = 1'b1;
            default: O_SEL_BOOT_ROM = 1'b0;
        endcase
    end

    assign O_SEL_EXTERNAL = ext_mode && !O_SEL_BOOT_ROM;
    assign O_START_ADDR = boot_mode ? BOOT_BASE : 16'h0000;
    assign O_PROTECTED = protect;
    assign O_FLASH_STALL = hv_busy;
    assign O_OP_DONE = hv_done;

    // only rom code in the upper region may launch a cycle
    always_comb
    begin
        start_op = I_OP_START && O_SEL_BOOT_ROM && in_top
            && !hv_busy;
        op_cycles = (func_code == FC_BYTE) ? 20'(WRITE_CYCLES)
            : 20'(ERASE_CYCLES);
        if (!(func_code == FC_BYTE || func_code == FC_PAGE
            || func_code == FC_BLOCK || func_code == FC_FULL))
            start_op = 1'b0;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            op <= OP_BYTE;
            op_addr <= '0;
            op_data <= '0;
        end
        else if (start_op)
        begin
            op_addr <= I_DATA_POINTER_PAIR[14:0];
            op_data <= I_ACC;
            case (func_code)
                FC_PAGE: op <= OP_PAGE;
                FC_BLOCK: op <= OP_BLOCK;
                FC_FULL: op <= OP_FULL;
                default: op <= OP_BYTE;
            endcase
        end
    end

    fbm_timer #(
        .WIDTH(20)
    ) u_timer (
        .I_CLK(I_CLK),
        .I_RESETN(I_RESETN),
        .i_start(start_op),
        .i_count(op_cycles),
        .o_busy(hv_busy),
        .o_done(hv_done)
    );

    always_comb
    begin
        case (op)
            OP_PAGE: erase_mask = 15'h7fff << PAGE_LSB;
            OP_BLOCK: erase_mask = 15'h7fff << BLOCK_LSB;
            OP_FULL: erase_mask = 15'h0000;
            default: erase_mask = 15'h7fff;
        endcase
    end

    // array update at cycle end; program only clears bits
    always_ff @(posedge I_CLK)
    begin
        if (hv_done)
        begin
            for (int i = 0; i < SIZE; i++)
            begin
                if (op != OP_BYTE
                    && ((15'(i) & erase_mask) == (op_addr & erase_mask)))
                    mem[i] <= ERASED;
            end
            if (op == OP_BYTE)
                mem[op_addr] <= mem[op_addr] & op_data;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            O_READ_DATA <= 8'h00;
        else if (I_READ_VALID && !hv_busy)
            O_READ_DATA <= mem[I_READ_ADDR];
    end
endmodule

// [verification/fbm_monitor.sv]
// port checker for the flash sequencer, bound into the top module
module fbm_monitor
    import fbm_pkg::*;
#(
    parameter int WRITE_CYCLES = 10,
    parameter int ERASE_CYCLES = 20
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic [15:0] I_FETCH_ADDR,
    input wire logic I_FETCH_VALID,
    input wire logic I_RETURN,
    input wire logic I_OP_START,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic O_SEL_BOOT_ROM,
    input wire logic O_FLASH_STALL,
    input wire logic O_OP_DONE
);
    timeunit 1ns;
    timeprecision 100ps;
    // slack of three edges covers launch and done registers
    localparam int WR_MAX = WRITE_CYCLES + 3;
    localparam int ER_MAX = ERASE_CYCLES + 3;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    AST_HV_FLAG: assert property (O_SFR_RDATA[BIT_PVF] == O_FLASH_STALL)
        else $error("voltage flag differs from busy");
    AST_RSV_ZERO: assert property (!O_SFR_RDATA[BIT_RSV])
        else $error("reserved bit reads one");
    AST_BYTE_TIME: assert property ((I_OP_START && !O_FLASH_STALL
        && O_SEL_BOOT_ROM && I_FETCH_ADDR >= BOOT_BASE
        && O_SFR_RDATA[3:0] == FC_BYTE) |=> ##[0:WR_MAX] O_OP_DONE)
        else $error("byte program late or missing");
    AST_ERASE_TIME: assert property ($rose(O_FLASH_STALL) |-> ##[1:ER_MAX] O_OP_DONE)
        else $error("operation not finished in time");
    AST_NO_LAUNCH: assert property ((I_OP_START && I_FETCH_ADDR < BOOT_BASE)
        |=> !$rose(O_FLASH_STALL))
        else $error("operation launched from user space");
    AST_DONE_END: assert property (O_OP_DONE |-> !O_FLASH_STALL && $past(O_FLASH_STALL))
        else $error("done without a blocked cycle before");
    AST_USER_MAP: assert property (O_SFR_RDATA[7:6] == 2'b00 |-> !O_SEL_BOOT_ROM)
        else $error("boot rom selected with user map");
    AST_ROM_ALL: assert property (O_SFR_RDATA[7:6] == 2'b11 |-> O_SEL_BOOT_ROM)
        else $error("boot rom not mapped over whole space");
    AST_LOW_MAP: assert property ((I_FETCH_VALID && I_FETCH_ADDR < BOOT_BASE
        && O_SFR_RDATA[7:6] == 2'b01) |-> !O_SEL_BOOT_ROM)
        else $error("boot rom selected below boundary");
    AST_RET_CLEAR: assert property ((I_FETCH_VALID && I_RETURN
        && I_FETCH_ADDR < BOOT_BASE && O_SFR_RDATA[7:6] == 2'b01)
        |=> O_SFR_RDATA[7:6] == 2'b00)
        else $error("select bits kept after return");
endmodule

bind fbm_top fbm_monitor #(
    .WRITE_CYCLES(WRITE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) u_mon (
    .I_CLK(I_CLK),
    .I_RESETN(I_RESETN),
    .I_FETCH_ADDR(I_FETCH_ADDR),
    .I_FETCH_VALID(I_FETCH_VALID),
    .I_RETURN(I_RETURN),
    .I_OP_START(I_OP_START),
    .O_SFR_RDATA(O_SFR_RDATA),
    .O_SEL_BOOT_ROM(O_SEL_BOOT_ROM),
    .O_FLASH_STALL(O_FLASH_STALL),
    .O_OP_DONE(O_OP_DONE)
);

// [verification/fbm_cpu_model.sv]
// cpu core model issuing fetches, register writes and flash calls
module fbm_cpu_model
    import fbm_pkg::*;
(
    input wire logic i_clk,
    output fbm_pkg::fbm_sfr_s o_sfr,
    output logic [15:0] o_fetch_addr,
    output logic o_fetch_valid,
    output logic o_return,
    output logic o_op_start,
    output logic [15:0] o_data_pointer_pair,
    output logic [7:0] o_acc
);
    timeunit 1ns;
    timeprecision 100ps;
    // no interrupts modelled, so every call runs with them off
    initial
    begin
        o_sfr = '0;
        o_fetch_addr = 16'h0000;
        o_fetch_valid = 1'b0;
        o_return = 1'b0;
        o_op_start = 1'b0;
        o_data_pointer_pair = 16'h0000;
        o_acc = 8'h00;
    end
    task automatic sfr_wr(input logic [7:0] d);
        @(posedge i_clk) #1;
        o_sfr = '{1'b1, FMC_ADDR, d & 8'hef};
        @(posedge i_clk) #1;
        o_sfr.sfr_we = 1'b0;
        o_sfr.sfr_wdata = ~d;
    endtask
    // select code only changed from below the boundary
    // jump above the boundary only after the select code is loaded
    task automatic call(input logic [15:0] a, input logic r, input logic s,
        input logic [15:0] dp, input logic [7:0] ac);
        @(posedge i_clk) #1;
        o_data_pointer_pair = dp;
        o_acc = ac;
        o_fetch_addr = a;
        o_fetch_valid = 1'b1;
        o_return = r;
        o_op_start = s;
        #1;
    endtask
    task automatic idle();
        @(posedge i_clk) #1;
        o_fetch_valid = 1'b0;
        o_return = 1'b0;
        o_op_start = 1'b0;
        o_fetch_addr = ~o_fetch_addr;
    endtask
endmodule

// [verification/tb_flash_control_boot_mapping.sv]
// testbench for the flash sequencer and boot mapping block
module tb_flash_control_boot_mapping
    import fbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WR = 10;
    localparam int ER = 20;
    logic clk, rstn, program_store_strobe_n, ale_n, ea_n, rd_valid, fv, ret, st;
    logic sel_boot, sel_ext, stall, done, prot;
    logic [14:0] rd_addr;
    logic [15:0] fa, dp, start_addr;
    logic [7:0] acc, sfr_rd, rd_data, d;
    fbm_sfr_s sfr;
    int fail_count, n_checks;
    // last entry programs the protection byte for the boot test
    logic [7:0] codes [6] = '{8'h4c, 8'h45, 8'h43, 8'h45, 8'h4a, 8'h45};
    logic [15:0] dps [6] = '{16'h1260, 16'h1263, 16'h1200, 16'h1263, 16'h0,
        16'h7fff};
    logic [7:0] accs [6] = '{8'h00, 8'h5a, 8'h00, 8'ha5, 8'h00, 8'h50};
    logic [7:0] exps [6] = '{8'hff, 8'h5a, 8'hff, 8'ha5, 8'hff, 8'hff};
    fbm_cpu_model u_cpu (.i_clk(clk), .o_sfr(sfr), .o_fetch_addr(fa),
        .o_fetch_valid(fv), .o_return(ret), .o_op_start(st), .o_data_pointer_pair(dp),
        .o_acc(acc));
    fbm_top #(.WRITE_CYCLES(WR), .ERASE_CYCLES(ER)) u_dut (.I_CLK(clk),
        .I_RESETN(rstn), .I_STRAP_PROGRAM_STORE_STROBE_N(program_store_strobe_n),
        .I_STRAP_ADDRESS_LATCH_N(ale_n),
        .I_STRAP_EXTERNAL_ACCESS_SELECT_N(ea_n), .I_SFR(sfr),
        .O_SFR_RDATA(sfr_rd), .I_FETCH_ADDR(fa), .I_FETCH_VALID(fv),
        .I_RETURN(ret), .I_DATA_POINTER_PAIR(dp), .I_ACC(acc),
        .I_OP_START(st), .I_READ_VALID(rd_valid), .I_READ_ADDR(rd_addr),
        .O_READ_DATA(rd_data), .O_SEL_BOOT_ROM(sel_boot),
        .O_SEL_EXTERNAL(sel_ext), .O_FLASH_STALL(stall),
        .O_START_ADDR(start_addr), .O_PROTECTED(prot), .O_OP_DONE(done));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic p, input logic a, input logic e);
        program_store_strobe_n = p;
        ale_n = a;
        ea_n = e;
        rstn = 1'b0;
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [14:0] a, output logic [7:0] q);
        @(posedge clk) #1;
        rd_valid = 1'b1;
        rd_addr = a;
        @(posedge clk) #1;
        rd_valid = 1'b0;
        q = rd_data;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 1000)
        begin
            @(posedge clk) #1;
            n++;
        end
    endtask
    task automatic t_reset();
        do_reset(1'b1, 1'b1, 1'b1);
        check(16'(sfr_rd), 16'h0000);
        check(start_addr, 16'h0000);
        check(16'(sel_ext), 16'h0000);
        check(16'(sel_boot), 16'h0000);
        check(16'(prot), 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_ops();
        for (int i = 0; i < 6; i++)
        begin
            u_cpu.sfr_wr(codes[i]);
            check(16'(sfr_rd), 16'(codes[i]));
            u_cpu.call(16'hffa0, 1'b0, 1'b1, dps[i], accs[i]);
            check(16'(sel_boot), 16'h0001);
            u_cpu.idle();
            check(16'(stall), 16'h0001);
            check(16'(sfr_rd[BIT_PVF]), 16'h0001);
            wait_done();
            check(16'(done), 16'h0001);
            rd(15'h1263, d);
            check(16'(d), 16'(exps[i]));
        end
        u_cpu.call(16'h0100, 1'b1, 1'b0, 16'h0000, 8'h00);
        u_cpu.idle();
        check(16'(sfr_rd[7:6]), 16'h0000);
        u_cpu.sfr_wr(8'h20);
        check(16'(sfr_rd), 16'h0000);
        u_cpu.sfr_wr(8'h80);
        check(16'(sfr_rd), 16'h0080);
        u_cpu.call(16'h0200, 1'b0, 1'b0, 16'h0000, 8'h00);
        u_cpu.idle();
        check(16'(sfr_rd[7:6]), 16'h0000);
        $display("operations test done");
    endtask
    task automatic t_boot();
        do_reset(1'b0, 1'b1, 1'b0);
        check(start_addr, BOOT_BASE);
        check(16'(sfr_rd[7:6]), 16'h0003);
        check(16'(sel_boot), 16'h0001);
        check(16'(prot), 16'h0001);
        u_cpu.sfr_wr(8'hc5);
        check(16'(sfr_rd), 16'h00c0);
        u_cpu.sfr_wr(8'hca);
        check(16'(sfr_rd), 16'h00ca);
        $display("boot strap test done");
    endtask
    initial
    begin
        #50000;
        fail_count++;
        results();
    end
    initial
    begin
        fail_count = 0;
        n_checks = 0;
        rd_valid = 1'b0;
        rd_addr = 15'h0000;
        t_reset();
        t_ops();
        t_boot();
        results();
    end
endmodule
